//--- dv/mst_motor_model.sv
// partner: stationary induction motor answering the tuning measurement
module mst_motor_model #(
  parameter logic [15:0] R1_VAL = 16'h00C8,
  parameter logic [15:0] EXC_VAL = 16'h0190
) (
  // inverter side
  input wire logic clock_i,
  input wire mst_pkg::mst_tune_state_t tune_state_i,
  // measured values
  output logic [15:0] meas_exc_o,
  output logic [15:0] meas_r1_o
);
  import mst_pkg::*;

  logic flip_q = 1'b0;
  logic meas_w;

  // pattern toggles each cycle, so stale values alternate between the true value and its inverse
  always @(posedge clock_i) begin
    flip_q <= !flip_q;
  end

  // connected motor at rest, load allowed; values valid only during a run
  assign meas_w = (tune_state_i == MST_T_BUSY);
  assign meas_r1_o = meas_w ? R1_VAL : ({16{flip_q}} ^ ~R1_VAL);
  assign meas_exc_o = meas_w ? EXC_VAL : ({16{flip_q}} ^ ~EXC_VAL);
endmodule : mst_motor_model

//--- dv/mst_motor_select_monitor.sv
// checker: port assertions for motor select and tuning
module mst_motor_select_monitor #(
  parameter int unsigned TUNE_CYCLES = 20
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // inputs watched
  input wire logic second_function_select_input_i,
  input wire logic [15:0] extended_display_select_i,
  input wire logic wr_valid_i,
  input wire mst_pkg::mst_param_t wr_sel_i,
  input wire logic [15:0] wr_data_i,
  // outputs watched
  input wire logic wr_ok_o,
  input wire logic wr_err_o,
  input wire logic [15:0] freq_out_o,
  input wire logic second_active_o,
  input wire logic second_set_o,
  input wire logic std_exc_o,
  input wire logic std_r1_o,
  input wire logic tune_enable_o,
  input wire mst_pkg::mst_tune_state_t tune_state_o
);
  import mst_pkg::*;

  logic [31:0] busy_cnt_q;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  // length of the current tuning run
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) busy_cnt_q <= 32'h0;
    else if (tune_state_o == MST_T_BUSY) busy_cnt_q <= busy_cnt_q + 32'h1;
    else busy_cnt_q <= 32'h0;
  end

  a_second_needs_pin: assert property (second_active_o |-> second_set_o)
    else $error("second motor active without selector");
  a_selector_on: assert property (
    second_function_select_input_i [*6] |-> second_set_o)
    else $error("selector level not followed");
  a_selector_off: assert property (
    !second_function_select_input_i [*6] |-> !second_set_o && !second_active_o)
    else $error("selector release not followed");
  a_locked_write: assert property (
    wr_valid_i && extended_display_select_i != 16'h0000 |=> wr_err_o && !wr_ok_o)
    else $error("write taken while display select not zero");
  a_bad_code: assert property (
    wr_valid_i && wr_sel_i == MST_P_APPLIED && wr_data_i == 16'h0002 |=> wr_err_o)
    else $error("invalid motor code taken");
  a_quiet_idle: assert property (!wr_valid_i |=> !wr_ok_o && !wr_err_o)
    else $error("write answer without request");
  a_tune_clamp: assert property (
    tune_state_o == MST_T_BUSY [*2] |-> freq_out_o <= MST_TUNE_FMAX)
    else $error("output frequency above limit while tuning");
  a_tune_length: assert property (
    tune_state_o == MST_T_OK && $past(tune_state_o) == MST_T_BUSY
      |-> busy_cnt_q + 32'h1 >= TUNE_CYCLES && busy_cnt_q <= TUNE_CYCLES + 1)
    else $error("tuning run length wrong");
  a_start_gated: assert property (
    tune_state_o == MST_T_BUSY && $past(tune_state_o) != MST_T_BUSY
      |-> tune_enable_o)
    else $error("tuning started while not enabled");
  a_std_after_reset: assert property (
    $rose(resetn_i) |-> std_exc_o && std_r1_o)
    else $error("standard constants not selected after reset");
endmodule : mst_motor_select_monitor

//--- dv/mst_motor_select_test.sv
// testbench: motor select, parameter store and offline tuning
module mst_motor_select_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mst_pkg::*;

  localparam logic [15:0] R1_VAL = 16'h00C8;
  localparam logic [15:0] EXC_VAL = 16'h0190;
  localparam logic [15:0] THERMAL_RST = 16'h0FA0; // drive rating default

  logic clock_i = 1'b0, resetn_i = 1'b0, pin_rt = 1'b0, pin_vf = 1'b0;
  logic run = 1'b0, wr_valid = 1'b0, wr_ok_o, wr_err_o, second_active_o;
  logic second_set_o, std_exc_o, std_r1_o, tune_enable_o;
  logic [15:0] ext = 16'h0000, wr_data = 16'h0000, freq_cmd = 16'h3A98;
  logic [15:0] rd_data_o, meas_exc, meas_r1, freq_out_o;
  logic [15:0] thermal_code_o, motor_const_code_o;
  mst_param_t wr_sel = MST_P_APPLIED, rd_sel = MST_P_APPLIED;
  mst_tune_state_t tune_state_o;
  int n_errors = 0, checks_done = 0, cycles = 0;
  logic [15:0] codes [9] = '{16'h0000, 16'h0001, 16'h0003, 16'h000D,
    16'h0017, 16'h0028, 16'h002B, 16'h0032, 16'h0035};

  mst_motor_select #(.TUNE_CYCLES(20)) dut_u (
    .clock_i(clock_i), .resetn_i(resetn_i),
    .second_function_select_input_i(pin_rt), .vf_control_switch_input_i(pin_vf),
    .run_cmd_i(run), .extended_display_select_i(ext), .wr_valid_i(wr_valid),
    .wr_sel_i(wr_sel), .wr_data_i(wr_data), .rd_sel_i(rd_sel),
    .rd_data_o(rd_data_o), .wr_ok_o(wr_ok_o), .wr_err_o(wr_err_o),
    .meas_exc_i(meas_exc), .meas_r1_i(meas_r1), .freq_cmd_i(freq_cmd),
    .freq_out_o(freq_out_o), .second_active_o(second_active_o),
    .second_set_o(second_set_o), .thermal_code_o(thermal_code_o),
    .motor_const_code_o(motor_const_code_o), .std_exc_o(std_exc_o),
    .std_r1_o(std_r1_o), .tune_enable_o(tune_enable_o),
    .tune_state_o(tune_state_o));

  mst_motor_model #(.R1_VAL(R1_VAL), .EXC_VAL(EXC_VAL)) motor_u (
    .clock_i(clock_i), .tune_state_i(tune_state_o),
    .meas_exc_o(meas_exc), .meas_r1_o(meas_r1));

  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    forever #10 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic flag(input string what, input logic exp, input logic got);
    check(what, {15'h0, exp}, {15'h0, got});
  endtask : flag

  task automatic wr(input mst_param_t sel, input logic [15:0] d,
                    input logic ok);
    @(negedge clock_i);
    wr_sel = sel;
    wr_data = d;
    wr_valid = 1'b1;
    @(negedge clock_i);
    wr_valid = 1'b0;
    flag("wr_ok", ok, wr_ok_o);
    flag("wr_err", !ok, wr_err_o);
  endtask : wr

  task automatic rd(input mst_param_t sel, input logic [15:0] exp);
    rd_sel = sel;
    @(negedge clock_i);
    check("rd_data", exp, rd_data_o);
  endtask : rd

  task automatic settle();
    repeat (8) @(negedge clock_i);
  endtask : settle

  // one tuning run, clamp checked while busy; cut drops run mid-way
  task automatic run_tune(input logic cut);
    int n;
    run = 1'b1;
    for (n = 0; n < 20 && tune_state_o !== MST_T_BUSY; n++) @(negedge clock_i);
    repeat (2) @(negedge clock_i);
    check("freq_out", MST_TUNE_FMAX, freq_out_o);
    if (cut) begin
      wr(MST_P_VOLT, 16'h0190, 1'b0);
      run = 1'b0;
    end
    for (n = 0; n < 60 && tune_state_o === MST_T_BUSY; n++) @(negedge clock_i);
    check("tune_state", cut ? 16'h0003 : 16'h0002,
          {14'h0, tune_state_o});
    run = 1'b0;
    settle();
  endtask : run_tune

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(MST_P_VOLT, MST_RST_VOLT);
    rd(MST_P_FREQ, MST_RST_FREQ);
    rd(MST_P_SECOND, MST_NONE);
    rd(MST_P_R1, MST_NONE);
    rd(MST_P_EXC, MST_NONE);
    rd(MST_P_THERMAL, THERMAL_RST);
    flag("std_r1", 1'b1, std_r1_o);
    flag("std_exc", 1'b1, std_exc_o);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_codes();
    foreach (codes[i]) begin
      wr(MST_P_APPLIED, codes[i], 1'b1);
      rd(MST_P_APPLIED, codes[i]);
      check("thermal", codes[i], thermal_code_o);
      check("const", codes[i], motor_const_code_o);
    end
    wr(MST_P_APPLIED, 16'h0002, 1'b0);
    wr(MST_P_APPLIED, 16'h0036, 1'b0);
    rd(MST_P_APPLIED, 16'h0035);
    ext = 16'h0001;
    wr(MST_P_VOLT, 16'h00E6, 1'b0);
    ext = 16'h0000;
    rd(MST_P_VOLT, MST_RST_VOLT);
    wr(MST_P_FREQ, 16'h03E7, 1'b0);
    wr(MST_P_VOLT, 16'h00E6, 1'b1);
    rd(MST_P_VOLT, 16'h00E6);
    $display("test codes and locks done");
  endtask : t_codes

  task automatic t_second();
    wr(MST_P_APPLIED, 16'h0003, 1'b1);
    pin_rt = 1'b1;
    settle();
    flag("second_active", 1'b0, second_active_o);
    check("thermal", 16'h0003, thermal_code_o);
    wr(MST_P_SECOND, 16'h0001, 1'b1);
    settle();
    flag("second_set", 1'b1, second_set_o);
    check("thermal", 16'h0001, thermal_code_o);
    flag("second_active", 1'b1, second_active_o);
    check("const", 16'h0001, motor_const_code_o);
    pin_rt = 1'b0;
    settle();
    check("thermal", 16'h0003, thermal_code_o);
    check("const", 16'h0003, motor_const_code_o);
    $display("test second motor done");
  endtask : t_second

  task automatic t_tune();
    wr(MST_P_TUNE, MST_TUNE_R1, 1'b1);
    wr(MST_P_THERMAL, 16'h0320, 1'b1);
    rd(MST_P_THERMAL, 16'h0320);
    run = 1'b1;
    settle();
    flag("tune_enable", 1'b0, tune_enable_o);
    check("tune_state", 16'h0000, {14'h0, tune_state_o});
    run = 1'b0;
    pin_vf = 1'b1;
    settle();
    flag("tune_enable", 1'b1, tune_enable_o);
    pin_vf = 1'b0;
    wr(MST_P_CAPACITY, 16'h000F, 1'b1);
    settle();
    flag("tune_enable", 1'b1, tune_enable_o);
    run_tune(1'b0);
    rd(MST_P_R1, R1_VAL);
    rd(MST_P_EXC, MST_NONE);
    flag("std_r1", 1'b0, std_r1_o);
    check("freq_out", freq_cmd, freq_out_o);
    wr(MST_P_TUNE, MST_TUNE_VF, 1'b1);
    run_tune(1'b0);
    rd(MST_P_EXC, EXC_VAL);
    flag("std_exc", 1'b0, std_exc_o);
    wr(MST_P_R1, 16'h0064, 1'b1);
    rd(MST_P_R1, 16'h0064);
    run_tune(1'b1);
    rd(MST_P_R1, 16'h0064);
    rd(MST_P_VOLT, 16'h00E6);
    $display("test tuning done");
  endtask : t_tune

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    repeat (20) @(negedge clock_i);
    resetn_i = 1'b1;
    t_reset();
    t_codes();
    t_second();
    t_tune();
    report_and_stop();
  end
endmodule : mst_motor_select_test

bind mst_motor_select mst_motor_select_monitor #(
  .TUNE_CYCLES(TUNE_CYCLES)
) mon_u (
  .clock_i(clock_i), .resetn_i(resetn_i),
  .second_function_select_input_i(second_function_select_input_i),
  .extended_display_select_i(extended_display_select_i),
  .wr_valid_i(wr_valid_i), .wr_sel_i(wr_sel_i), .wr_data_i(wr_data_i),
  .wr_ok_o(wr_ok_o), .wr_err_o(wr_err_o), .freq_out_o(freq_out_o),
  .second_active_o(second_active_o), .second_set_o(second_set_o),
  .std_exc_o(std_exc_o), .std_r1_o(std_r1_o),
  .tune_enable_o(tune_enable_o), .tune_state_o(tune_state_o));

//--- hdl/mst_motor_select.sv
// motor selection, parameter store and offline tuning gate
module mst_motor_select #(
  parameter int unsigned TUNE_CYCLES = mst_pkg::MST_TUNE_CYCLES,
  parameter logic [15:0] THERMAL_RESET = 16'h0FA0 // rated drive current
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // terminal inputs (asynchronous pins)
  input wire logic second_function_select_input_i,
  input wire logic vf_control_switch_input_i,
  input wire logic run_cmd_i,
  // parameter write and read
  input wire logic [15:0] extended_display_select_i,
  input wire logic wr_valid_i,
  input wire mst_pkg::mst_param_t wr_sel_i,
  input wire logic [15:0] wr_data_i,
  input wire mst_pkg::mst_param_t rd_sel_i,
  output logic [15:0] rd_data_o,
  output logic wr_ok_o,
  output logic wr_err_o,
  // measurement results
  input wire logic [15:0] meas_exc_i,
  input wire logic [15:0] meas_r1_i,
  // frequency path
  input wire logic [15:0] freq_cmd_i,
  output logic [15:0] freq_out_o,
  // motor selection
  output logic second_active_o,
  output logic second_set_o,
  output logic [15:0] thermal_code_o,
  output logic [15:0] motor_const_code_o,
  output logic std_exc_o,
  output logic std_r1_o,
  // tuning status
  output logic tune_enable_o,
  output mst_pkg::mst_tune_state_t tune_state_o
);
  import mst_pkg::*;

  // elaboration check: the run timer cannot serve fewer than two cycles
  if (TUNE_CYCLES < 2) begin : g_cycles_check
    $error("mst_motor_select: TUNE_CYCLES must be at least 2");
  end

  // ---------------------------------------------------------------
  // pin synchronisers: three stages, change when stages 2 and 3 agree
  // ---------------------------------------------------------------
  logic [2:0] rt_s_q;
  logic [2:0] vf_s_q;
  logic [2:0] run_s_q;
  logic rt_q;
  logic vf_q;
  logic run_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rt_s_q <= 3'h0;
      vf_s_q <= 3'h0;
      run_s_q <= 3'h0;
    end else begin
      rt_s_q <= {rt_s_q[1:0], second_function_select_input_i};
      vf_s_q <= {vf_s_q[1:0], vf_control_switch_input_i};
      run_s_q <= {run_s_q[1:0], run_cmd_i};
    end
  end

  // filtered levels
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rt_q <= 1'b0;
      vf_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      if (rt_s_q[1] == rt_s_q[2]) rt_q <= rt_s_q[2];
      if (vf_s_q[1] == vf_s_q[2]) vf_q <= vf_s_q[2];
      if (run_s_q[1] == run_s_q[2]) run_q <= run_s_q[2];
    end
  end

  // ---------------------------------------------------------------
  // parameter store
  // ---------------------------------------------------------------
  logic [15:0] applied_q;
  logic [15:0] second_q;
  logic [15:0] capacity_q;
  logic [15:0] exc_q;
  logic [15:0] volt_q;
  logic [15:0] freq_q;
  logic [15:0] r1_q;
  logic [15:0] tune_q;
  logic [15:0] thermal_q;
  logic val_ok;
  logic busy;
  logic done;

  mst_param_check u_check (
    .sel_i(wr_sel_i),
    .data_i(wr_data_i),
    .ok_o(val_ok)
  );

  // write accepted only when shown, in range and no run is in progress
  wire logic edit_open = (extended_display_select_i == MST_EXT_SHOWN);
  wire logic wr_take = wr_valid_i && edit_open && val_ok && !busy;
  wire logic wr_drop = wr_valid_i && !wr_take;
  // stationary mode stores resistance only, restart mode stores both
  wire logic store_r1 = done;
  wire logic store_exc = done && (tune_q == MST_TUNE_VF);

  // stored parameters; a tuning result beats a write in the same cycle
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      applied_q <= MST_RST_APPLIED;
      second_q <= MST_NONE;
      capacity_q <= MST_NONE;
      exc_q <= MST_NONE;
      volt_q <= MST_RST_VOLT;
      freq_q <= MST_RST_FREQ;
      r1_q <= MST_NONE;
      tune_q <= MST_TUNE_OFF;
      thermal_q <= 16'h0000;
    end else begin
      if (wr_take && wr_sel_i == MST_P_APPLIED) applied_q <= wr_data_i;
      if (wr_take && wr_sel_i == MST_P_SECOND) second_q <= wr_data_i;
      if (wr_take && wr_sel_i == MST_P_CAPACITY) capacity_q <= wr_data_i;
      if (wr_take && wr_sel_i == MST_P_VOLT) volt_q <= wr_data_i;
      if (wr_take && wr_sel_i == MST_P_FREQ) freq_q <= wr_data_i;
      if (wr_take && wr_sel_i == MST_P_TUNE) tune_q <= wr_data_i;
      if (wr_take && wr_sel_i == MST_P_THERMAL) thermal_q <= wr_data_i;
      if (store_exc) begin
        exc_q <= meas_exc_i;
      end else if (wr_take && wr_sel_i == MST_P_EXC) begin
        exc_q <= wr_data_i;
      end
      if (store_r1) begin
        r1_q <= meas_r1_i;
      end else if (wr_take && wr_sel_i == MST_P_R1) begin
        r1_q <= wr_data_i;
      end
    end
  end

  // thermal current takes the drive rating once, after reset release
  logic thermal_init_q;
  logic [15:0] thermal_eff;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      thermal_init_q <= 1'b0;
    end else if (wr_take && wr_sel_i == MST_P_THERMAL) begin
      thermal_init_q <= 1'b1;
    end
  end

  assign thermal_eff = thermal_init_q ? thermal_q : THERMAL_RESET;

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [15:0] rd_mux;

  // read selection, also used for copying to another unit
  always_comb begin
    unique case (rd_sel_i)
      MST_P_APPLIED: rd_mux = applied_q;
      MST_P_SECOND: rd_mux = second_q;
      MST_P_CAPACITY: rd_mux = capacity_q;
      MST_P_EXC: rd_mux = exc_q;
      MST_P_VOLT: rd_mux = volt_q;
      MST_P_FREQ: rd_mux = freq_q;
      MST_P_R1: rd_mux = r1_q;
      MST_P_TUNE: rd_mux = tune_q;
      MST_P_THERMAL: rd_mux = thermal_eff;
      default: rd_mux = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // motor selection
  // ---------------------------------------------------------------
  wire logic second_valid = (second_q != MST_NONE);
  wire logic second_on = second_valid && rt_q;
  wire logic flux_vector = (capacity_q != MST_NONE);

  // ---------------------------------------------------------------
  // tuning gate and run control
  // ---------------------------------------------------------------
  wire logic tune_armed = (tune_q == MST_TUNE_R1) || (tune_q == MST_TUNE_VF);
  wire logic tune_ok = flux_vector || vf_q;
  // shaft load is not checked, so a loaded motor still tunes
  wire logic tune_go = tune_armed && tune_ok;
  logic run_d1_q;
  logic rt_d1_q;
  wire logic run_rise = run_q && !run_d1_q;
  wire logic start = run_rise && tune_go && !busy;
  // run off or a second function toggle spoils the measurement
  wire logic abort = busy && (!run_q || (rt_q != rt_d1_q));

  mst_tune_timer #(
    .CYCLES(TUNE_CYCLES)
  ) u_timer (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .start_i(start),
    .abort_i(abort),
    .busy_o(busy),
    .done_o(done)
  );

  // tuning outcome state
  mst_tune_state_t state_q;
  mst_tune_state_t state_d;

  // busy waits for abort or done; any other state waits for a start
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MST_T_BUSY: begin
        if (abort) begin
          state_d = MST_T_ERROR;
        end else if (done) begin
          state_d = MST_T_OK;
        end
      end
      MST_T_IDLE, MST_T_OK, MST_T_ERROR: begin
        if (start) begin
          state_d = MST_T_BUSY;
        end
      end
    endcase
  end

  // edge history and state
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_d1_q <= 1'b0;
      rt_d1_q <= 1'b0;
      state_q <= MST_T_IDLE;
    end else begin
      run_d1_q <= run_q;
      rt_d1_q <= rt_q;
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  wire logic [15:0] freq_lim = (freq_cmd_i > MST_TUNE_FMAX) ?
                               MST_TUNE_FMAX : freq_cmd_i;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o <= 16'h0000;
      wr_ok_o <= 1'b0;
      wr_err_o <= 1'b0;
      freq_out_o <= 16'h0000;
      second_active_o <= 1'b0;
      second_set_o <= 1'b0;
      thermal_code_o <= MST_RST_APPLIED;
      motor_const_code_o <= MST_RST_APPLIED;
      std_exc_o <= 1'b1;
      std_r1_o <= 1'b1;
      tune_enable_o <= 1'b0;
    end else begin
      rd_data_o <= rd_mux;
      wr_ok_o <= wr_take;
      wr_err_o <= wr_drop;
      freq_out_o <= busy ? freq_lim : freq_cmd_i;
      second_active_o <= second_on;
      second_set_o <= rt_q;
      thermal_code_o <= second_on ? second_q : applied_q;
      motor_const_code_o <= second_on ? second_q : applied_q;
      std_exc_o <= (exc_q == MST_NONE);
      std_r1_o <= (r1_q == MST_NONE);
      tune_enable_o <= tune_go;
    end
  end

  assign tune_state_o = state_q;

endmodule : mst_motor_select

//--- hdl/mst_param_check.sv
// range check of a parameter write value
module mst_param_check (
  // candidate write
  input wire mst_pkg::mst_param_t sel_i,
  input wire logic [15:0] data_i,
  // verdict
  output logic ok_o
);
  import mst_pkg::*;

  // ---------------------------------------------------------------
  // per-parameter setting range
  // ---------------------------------------------------------------
  // one verdict per parameter, selected below
  wire logic ok_applied = mst_motor_ok(data_i);
  wire logic ok_second = (data_i == MST_MOTOR_STD) ||
                         (data_i == MST_MOTOR_CT) || (data_i == MST_NONE);
  wire logic ok_cap = mst_in_range(data_i, MST_CAP_MIN, MST_CAP_MAX, 1'b1);
  wire logic ok_exc = mst_in_range(data_i, 16'h0000, MST_EXC_MAX, 1'b1);
  wire logic ok_volt = mst_in_range(data_i, 16'h0000, MST_VOLT_MAX, 1'b0);
  wire logic ok_freq = mst_in_range(data_i, MST_FREQ_MIN, MST_FREQ_MAX, 1'b0);
  wire logic ok_r1 = mst_in_range(data_i, 16'h0000, MST_R1_MAX, 1'b1);
  wire logic ok_tune = (data_i == MST_TUNE_OFF) || (data_i == MST_TUNE_R1) ||
                       (data_i == MST_TUNE_VF);

  // selection of the verdict; unknown ids are refused
  always_comb begin
    unique case (sel_i)
      MST_P_APPLIED: ok_o = ok_applied;
      MST_P_SECOND: ok_o = ok_second;
      MST_P_CAPACITY: ok_o = ok_cap;
      MST_P_EXC: ok_o = ok_exc;
      MST_P_VOLT: ok_o = ok_volt;
      MST_P_FREQ: ok_o = ok_freq;
      MST_P_R1: ok_o = ok_r1;
      MST_P_TUNE: ok_o = ok_tune;
      MST_P_THERMAL: ok_o = 1'b1;
      default: ok_o = 1'b0;
    endcase
  end

endmodule : mst_param_check

//--- hdl/mst_pkg.sv
// package: parameter ids, codes, ranges and timing for motor select and tuning
package mst_pkg;

  // ---------------------------------------------------------------
  // parameter identifiers on the write and read ports
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    MST_P_APPLIED  = 4'h0, // applied_motor_code
    MST_P_SECOND   = 4'h1, // second_motor_select
    MST_P_CAPACITY = 4'h2, // motor_capacity_param, 0.1 kW units
    MST_P_EXC      = 4'h3, // excitation_current_param, 0.01 A units
    MST_P_VOLT     = 4'h4, // rated_voltage_param, 1 V units
    MST_P_FREQ     = 4'h5, // rated_frequency_param, 0.01 Hz units
    MST_P_R1       = 4'h6, // stator_resistance_constant, 0.01 ohm units
    MST_P_TUNE     = 4'h7, // tuning_setting_status
    MST_P_THERMAL  = 4'h8  // thermal_overload_current, 0.01 A units
  } mst_param_t;

  typedef enum logic [1:0] {
    MST_T_IDLE  = 2'b00,
    MST_T_BUSY  = 2'b01,
    MST_T_OK    = 2'b10,
    MST_T_ERROR = 2'b11
  } mst_tune_state_t;

  // ---------------------------------------------------------------
  // codes and ranges
  // ---------------------------------------------------------------
  localparam logic [15:0] MST_NONE = 16'h270F;          // 9999
  localparam logic [15:0] MST_MOTOR_STD = 16'h0000;
  localparam logic [15:0] MST_MOTOR_CT = 16'h0001;
  localparam logic [15:0] MST_MOTOR_STD_T = 16'h0003;
  localparam logic [15:0] MST_MOTOR_CT_T = 16'h000D;
  localparam logic [15:0] MST_MOTOR_SMALL_T = 16'h0017;
  localparam logic [15:0] MST_MOTOR_HE = 16'h0028;
  localparam logic [15:0] MST_MOTOR_HE_T = 16'h002B;
  localparam logic [15:0] MST_MOTOR_CT2 = 16'h0032;
  localparam logic [15:0] MST_MOTOR_CT2_T = 16'h0035;
  localparam logic [15:0] MST_TUNE_OFF = 16'h0000;      // 0
  localparam logic [15:0] MST_TUNE_R1 = 16'h000B;       // 11
  localparam logic [15:0] MST_TUNE_VF = 16'h0015;       // 21
  localparam logic [15:0] MST_CAP_MIN = 16'h0001;       // 0.1 kW
  localparam logic [15:0] MST_CAP_MAX = 16'h004B;       // 7.5 kW
  localparam logic [15:0] MST_EXC_MAX = 16'hC350;       // 500 A
  localparam logic [15:0] MST_VOLT_MAX = 16'h03E8;      // 1000 V
  localparam logic [15:0] MST_FREQ_MIN = 16'h03E8;      // 10 Hz
  localparam logic [15:0] MST_FREQ_MAX = 16'h2EE0;      // 120 Hz
  localparam logic [15:0] MST_R1_MAX = 16'h1388;        // 50 ohm
  localparam logic [15:0] MST_TUNE_FMAX = 16'h2EE0;     // 120 Hz limit

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] MST_RST_APPLIED = 16'h0000;
  localparam logic [15:0] MST_RST_VOLT = 16'h0190;      // 400 V
  localparam logic [15:0] MST_RST_FREQ = 16'h1388;      // 50 Hz
  localparam logic [15:0] MST_EXT_SHOWN = 16'h0000;     // edit allowed

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned MST_CLK_HZ = 50000000;
  localparam int unsigned MST_TUNE_TIME_S = 9;          // approx 9 s run
  localparam int unsigned MST_TUNE_CYCLES = MST_TUNE_TIME_S * MST_CLK_HZ;

  // ---------------------------------------------------------------
  // decoding functions
  // ---------------------------------------------------------------
  // accepted applied motor codes
  function automatic logic mst_motor_ok(input logic [15:0] v);
    mst_motor_ok = (v == MST_MOTOR_STD) || (v == MST_MOTOR_CT) ||
      (v == MST_MOTOR_STD_T) || (v == MST_MOTOR_CT_T) ||
      (v == MST_MOTOR_SMALL_T) || (v == MST_MOTOR_HE) ||
      (v == MST_MOTOR_HE_T) || (v == MST_MOTOR_CT2) ||
      (v == MST_MOTOR_CT2_T);
  endfunction : mst_motor_ok

  // value is within range, or the 9999 code where allowed
  function automatic logic mst_in_range(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi,
                                        input logic none_ok);
    mst_in_range = ((v >= lo) && (v <= hi)) || (none_ok && (v == MST_NONE));
  endfunction : mst_in_range

endpackage : mst_pkg

//--- hdl/mst_tune_timer.sv
// run timer of a stationary tuning measurement
module mst_tune_timer #(
  parameter int unsigned CYCLES = mst_pkg::MST_TUNE_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // control
  input wire logic start_i,
  input wire logic abort_i,
  // status
  output logic busy_o,
  output logic done_o
);
  import mst_pkg::*;

  localparam int W = $clog2(CYCLES + 1);

  // elaboration check: a run needs at least two counted cycles
  if (CYCLES < 2) begin : g_cycles_check
    $error("mst_tune_timer: CYCLES must be at least 2");
  end

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;

  // ---------------------------------------------------------------
  // count down from start; abort ends the run without done
  // ---------------------------------------------------------------
  wire logic last = busy_q && (cnt_q == W'(1));

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (abort_i) begin
      busy_d = 1'b0;
    end else if (start_i && !busy_q) begin
      busy_d = 1'b1;
      cnt_d = W'(CYCLES);
    end else if (last) begin
      busy_d = 1'b0;
      done_d = 1'b1;
    end else if (busy_q) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  // timer state
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;

endmodule : mst_tune_timer
